// ==== rtl/rx_bp_port.sv ====
// receive backplane port: elastic frame buffer, t1/e1-rate mapping and backplane
// timing for master, slave and multiplexed operation, with an AHB-Lite register slave.
// assumes every pin input is asynchronous to mclk and that line_frame_start marks the F-bit.
//
// The AHB-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// What this block does
// - master mode drives clock and pulse; pulse and data change on selected edges.
// - unequal edge selects place the frame pulse ahead of its data.
// - master pulse marks each F-bit, multiframe starts, or every second of either.
// - frame pulse invert bit sets pulse polarity, driven or sampled.
// - full master outputs continuous clock, F-bit and all 24 channels.
// - fractional master gaps clock on F-bit, selected channels or their bit 8.
// - slave rate is t1 passthrough or e1 rate remapped by the mapping field.
// - standard mapping puts channels 1-15 in slots 1-15, 16-24 in 17-25.
// - standard mapping carries next frame F-bit in slot 26 bit 1; rest zero.
// - filler mapping inserts a zero byte before every 3 channels, F-bit as bit 8.
// - continuous mapping puts channels in slots 1-24, F-bit as bit 8, rest zero.
// - slave mode samples supplied pulse on frame edge, updates data on data edge.
// - in slave and multiplexed modes, clock double bit selects clock equal to or twice the bit rate.
// - double clock updates data on chosen edge, samples pulse on first edge.
// - misplaced frame pulse sets offset flag; enabled flag asserts the interrupt.
// - multiplexed mode remaps to e1 format then byte-interleaves at the chosen slot.
// - multiplexed clock and pulse are supplied, at bit rate or double rate.
// - signaling output stays channel-aligned with its data on every output.
// - multiplex and slave select bits choose master, slave or multiplexed mode.
// - master timing follows the recovered line clock, mclk-derived while lost.
module rx_bp_port import rx_bp_pkg::*; #(
    parameter int LOS_HALF = LOS_HALF_CYCLES
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic line_clk,
    input wire logic line_data,
    input wire logic line_sig,
    input wire logic line_frame_start,
    input wire logic line_mf_start,
    input wire logic line_los,
    input wire logic rx_bp_clock_in,
    output logic rx_bp_clock_out,
    output logic rx_bp_clock_oe,
    input wire logic rx_bp_frame_pulse_in,
    output logic rx_bp_frame_pulse_out,
    output logic rx_bp_frame_pulse_oe,
    output logic rx_bp_data_out,
    output logic rx_bp_signaling_out,
    input wire logic mux_bp_clock,
    input wire logic mux_bp_frame_pulse,
    output logic mux_bp_data_out,
    output logic mux_bp_signaling_out,
    output logic mux_bp_data_oe,
    output logic frame_pulse_irq
);
    localparam int NPIN = 10;
    localparam int MEM_BITS = 2 * T1_FRAME_BITS;

    // the divider counter is four bits wide
    if (LOS_HALF < 1 || LOS_HALF > 16) begin
        $error("LOS_HALF must lie between 1 and 16");
    end

    // two-stage synchronisers for every pin input
    logic [NPIN-1:0] pin_raw, pin_meta, pin_sync;
    assign pin_raw = {line_clk, mux_bp_frame_pulse, mux_bp_clock, rx_bp_frame_pulse_in, rx_bp_clock_in,
                      line_los, line_mf_start, line_frame_start, line_sig, line_data};
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
        end
    end
    logic lclk_sync, s_data, s_sig, s_fs, s_mf, s_los, s_bpclk, s_bpfp, s_muxclk, s_muxfp;
    assign {lclk_sync, s_muxfp, s_muxclk, s_bpfp, s_bpclk, s_los, s_mf, s_fs, s_sig, s_data} = pin_sync;

    // registers
    logic [CTRL_WIDTH-1:0] ctrl, next_ctrl;
    logic [T1_CHANNELS-1:0] ch_gap, next_ch_gap, b8_gap, next_b8_gap;
    logic offset_flag, next_offset_flag;
    logic [7:0] dph_addr, next_dph_addr;
    logic dph_write, next_dph_write;
    logic [31:0] next_hrdata;
    logic offset_event;
    logic locked;

    logic mux_sel, slave_sel, fe_rise, de_rise, fp_inv, dbl;
    logic [1:0] map_sel, mux_slot;
    mode_e mode;
    assign mux_sel = ctrl[MUX_SEL_BIT];
    assign slave_sel = ctrl[SLAVE_SEL_BIT];
    assign fe_rise = ctrl[FRAME_EDGE_BIT];
    assign de_rise = ctrl[DATA_EDGE_BIT];
    assign fp_inv = ctrl[FP_INVERT_BIT];
    assign map_sel = ctrl[MAP_LSB +: 2];
    assign mux_slot = ctrl[MUX_SLOT_LSB +: 2];
    assign mode = mux_sel ? MODE_MUX : (slave_sel ? MODE_SLAVE : MODE_MASTER);
    assign dbl = ctrl[CLK_DOUBLE_BIT] && (mode != MODE_MASTER);

    always_comb begin
        next_ctrl = ctrl;
        next_ch_gap = ch_gap;
        next_b8_gap = b8_gap;
        next_dph_addr = dph_addr;
        next_dph_write = 1'b0;
        next_hrdata = hrdata;
        // a new offset event wins over a same-cycle clear
        next_offset_flag = offset_flag;
        if (dph_write) begin
            case (dph_addr)
                CTRL_ADDR: next_ctrl = hwdata[CTRL_WIDTH-1:0];
                CH_GAP_ADDR: next_ch_gap = hwdata[T1_CHANNELS-1:0];
                B8_GAP_ADDR: next_b8_gap = hwdata[T1_CHANNELS-1:0];
                STATUS_ADDR: if (hwdata[OFFSET_FLAG_BIT]) next_offset_flag = 1'b0;
                default: next_offset_flag = offset_flag;
            endcase
        end
        if (offset_event) next_offset_flag = 1'b1;
        if (hsel && hready && htrans[1]) begin
            next_dph_addr = {haddr[7:2], 2'b00};
            next_dph_write = hwrite;
            next_hrdata = '0;
            if (!hwrite && haddr[31:8] == '0) begin
                case ({haddr[7:2], 2'b00})
                    CTRL_ADDR: next_hrdata[CTRL_WIDTH-1:0] = ctrl;
                    CH_GAP_ADDR: next_hrdata[T1_CHANNELS-1:0] = ch_gap;
                    B8_GAP_ADDR: next_hrdata[T1_CHANNELS-1:0] = b8_gap;
                    STATUS_ADDR: begin
                        next_hrdata[OFFSET_FLAG_BIT] = offset_flag;
                        next_hrdata[LOCKED_BIT] = locked;
                    end
                    default: next_hrdata = '0;
                endcase
            end
            if (haddr[31:8] != '0) next_dph_addr = '1;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ctrl <= CTRL_RESET;
            ch_gap <= '0;
            b8_gap <= '0;
            offset_flag <= 1'b0;
            dph_addr <= '0;
            dph_write <= 1'b0;
            hrdata <= '0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            frame_pulse_irq <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            ch_gap <= next_ch_gap;
            b8_gap <= next_b8_gap;
            offset_flag <= next_offset_flag;
            dph_addr <= next_dph_addr;
            dph_write <= next_dph_write;
            hrdata <= next_hrdata;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            frame_pulse_irq <= next_offset_flag && next_ctrl[OFFSET_IRQ_EN_BIT];
        end
    end

    // write side of the elastic buffer, timed by the recovered line clock
    logic data_mem [0:MEM_BITS-1];
    logic sig_mem [0:MEM_BITS-1];
    logic [1:0] mf_mark, next_mf_mark;
    logic wr_bank, next_wr_bank, lclk_prev;
    logic [7:0] wr_pos, next_wr_pos;
    logic line_tick;
    logic [8:0] wr_addr;
    assign line_tick = lclk_sync && !lclk_prev;

    always_comb begin
        next_wr_bank = wr_bank;
        next_wr_pos = wr_pos;
        next_mf_mark = mf_mark;
        wr_addr = {1'b0, wr_pos} + (wr_bank ? 9'(T1_FRAME_BITS) : 9'h000);
        if (line_tick) begin
            if (s_fs) begin
                // the F-bit opens the other bank, so the reader keeps a whole frame
                next_wr_bank = !wr_bank;
                next_wr_pos = 8'h01;
                next_mf_mark[!wr_bank] = s_mf;
                wr_addr = wr_bank ? 9'h000 : 9'(T1_FRAME_BITS);
            end else if (wr_pos != T1_LAST_BIT[7:0]) begin
                next_wr_pos = wr_pos + 8'h01;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wr_bank <= 1'b0;
            wr_pos <= '0;
            mf_mark <= '0;
            lclk_prev <= 1'b0;
        end else begin
            wr_bank <= next_wr_bank;
            wr_pos <= next_wr_pos;
            mf_mark <= next_mf_mark;
            lclk_prev <= lclk_sync;
        end
    end
    always_ff @(posedge mclk) begin
        if (line_tick) begin
            data_mem[wr_addr] <= s_data;
            sig_mem[wr_addr] <= s_sig;
        end
    end

    // maps a backplane bit position to its source in the t1 frame
    function automatic logic [9:0] map_src(input logic [9:0] pos, input mode_e md, input logic [1:0] mp);
        logic [4:0] ts;
        logic [2:0] b;
        logic [7:0] ch;
        src_e s;
        ts = pos[7:3];
        b = pos[2:0];
        ch = 8'h00;
        s = SRC_ZERO;
        if (md == MODE_MUX) begin
            ts = pos[9:5];
        end
        if (md != MODE_MUX && mp == MAP_T1_RATE) begin
            return {SRC_CUR, pos[7:0]};
        end
        case (mp)
            MAP_STANDARD: begin
                if (ts >= 5'h01 && ts <= TS_STD_LOW_END) ch = {3'h0, ts};
                if (ts >= TS_STD_HIGH_START && ts <= TS_STD_HIGH_END) ch = {3'h0, ts} - 8'h01;
                if (ts == TS_STD_FBIT && b == STD_FBIT_POS) s = SRC_NEXT_FBIT;
            end
            MAP_FILLER: begin
                if (ts[1:0] != 2'h0) ch = {3'h0, ts} - {5'h00, ts[4:2]};
                if (ts == 5'h00 && b == BIT8_POS) s = SRC_CUR;
            end
            default: begin
                if (ts >= 5'h01 && ts <= TS_CONT_END) ch = {3'h0, ts};
                if (ts == 5'h00 && b == BIT8_POS) s = SRC_CUR;
            end
        endcase
        if (ch != 8'h00) begin
            return {SRC_CUR, 8'(8'h01 + {ch - 8'h01, 3'h0} + {5'h00, (md == MODE_MUX) ? pos[2:0] : b})};
        end
        return {s, 8'h00};
    endfunction

    // backplane timing source
    logic [3:0] los_cnt, next_los_cnt;
    logic los_clk, next_los_clk, src_level, src_prev;
    logic src_rise, src_fall, data_edge, fp_edge, phase, next_phase;
    logic data_tick, fp_sample, fp_level, start_pending, next_start_pending;
    logic [9:0] pos, next_pos, last_bit, ahead_pos;
    logic rd_bank, next_rd_bank, alt_tog, next_alt_tog, next_locked;
    logic next_clk_out, next_fp_out, next_data, next_sig, next_mux_oe;
    logic gap_now, fp_hit, fp_select;
    logic [9:0] src;
    logic [7:0] tch;
    logic [8:0] rd_addr;

    always_comb begin
        next_los_cnt = los_cnt + 4'h1;
        next_los_clk = los_clk;
        if (los_cnt == 4'(LOS_HALF - 1)) begin
            next_los_cnt = '0;
            next_los_clk = !los_clk;
        end
        case (mode)
            MODE_MASTER: src_level = s_los ? los_clk : lclk_sync;
            MODE_SLAVE: src_level = s_bpclk;
            MODE_MUX: src_level = s_muxclk;
            default: src_level = 1'b0;
        endcase
        src_rise = src_level && !src_prev;
        src_fall = !src_level && src_prev;
        data_edge = de_rise ? src_rise : src_fall;
        fp_edge = fe_rise ? src_rise : src_fall;
        // a double clock carries two active edges per bit
        data_tick = data_edge && (!dbl || phase == ctrl[DOUBLE_EDGE_BIT]);
        next_phase = data_edge ? !phase : phase;
        fp_level = ((mode == MODE_MUX) ? s_muxfp : s_bpfp) ^ fp_inv;
        fp_sample = (mode != MODE_MASTER) && fp_edge && fp_level && (!dbl || !phase);
        case (mode)
            MODE_MUX: last_bit = MUX_LAST_BIT;
            MODE_SLAVE: last_bit = (map_sel == MAP_T1_RATE) ? T1_LAST_BIT : E1_LAST_BIT;
            default: last_bit = T1_LAST_BIT;
        endcase
        next_pos = pos;
        next_start_pending = start_pending;
        next_locked = locked;
        offset_event = 1'b0;
        ahead_pos = (pos >= last_bit) ? 10'h000 : pos + 10'h001;
        if (fp_sample) begin
            // the last bit must be out, or go out on a data edge of this same cycle
            offset_event = locked && (data_tick ? ahead_pos : pos) != last_bit;
            next_locked = 1'b1;
            next_start_pending = 1'b1;
            if (dbl) next_phase = 1'b1;
        end
        if (data_tick) begin
            next_pos = (start_pending || pos >= last_bit) ? 10'h000 : pos + 10'h001;
            next_start_pending = fp_sample;
        end
        if (mode == MODE_MASTER) next_locked = 1'b0;
        next_rd_bank = (data_tick && next_pos == 10'h000) ? !wr_bank : rd_bank;
        src = map_src(next_pos, mode, map_sel);
        case (src_e'(src[9:8]))
            SRC_CUR: rd_addr = {1'b0, src[7:0]} + (next_rd_bank ? 9'(T1_FRAME_BITS) : 9'h000);
            SRC_NEXT_FBIT: rd_addr = next_rd_bank ? 9'h000 : 9'(T1_FRAME_BITS);
            default: rd_addr = '0;
        endcase
        next_data = rx_bp_data_out;
        next_sig = rx_bp_signaling_out;
        next_mux_oe = (mode == MODE_MUX) && mux_bp_data_oe;
        if (data_tick) begin
            // data and signaling share one address, so they stay channel-aligned
            next_data = (src[9:8] == SRC_ZERO) ? 1'b0 : data_mem[rd_addr];
            next_sig = (src[9:8] == SRC_ZERO) ? 1'b0 : sig_mem[rd_addr];
            next_mux_oe = (mode == MODE_MUX) && (next_pos[4:3] == mux_slot);
        end
        // master frame pulse: F-bit, multiframe start, optionally every second one
        fp_select = (!ctrl[MF_PULSE_BIT] || mf_mark[!wr_bank]) && !alt_tog;
        next_alt_tog = alt_tog;
        if (data_tick && next_pos == 10'h000 && (!ctrl[MF_PULSE_BIT] || mf_mark[!wr_bank])) begin
            next_alt_tog = ctrl[ALT_PULSE_BIT] ? !alt_tog : 1'b0;
        end
        // with unequal edges the pulse follows the coming bit, so it leads its data
        fp_hit = data_tick ? (next_pos == 10'h000) : (de_rise != fe_rise && ahead_pos == 10'h000);
        next_fp_out = rx_bp_frame_pulse_out;
        if (mode == MODE_MASTER && fp_edge) next_fp_out = (fp_hit && fp_select) ^ fp_inv;
        if (mode != MODE_MASTER) next_fp_out = fp_inv;
        tch = (pos == 10'h000) ? 8'h00 : 8'((pos - 10'h001) >> 3);
        gap_now = (pos == 10'h000) ? ctrl[FBIT_GAP_BIT] :
            (ctrl[PAYLOAD_EN_BIT] && tch < 8'(T1_CHANNELS) &&
            (ch_gap[tch[4:0]] || (b8_gap[tch[4:0]] && pos[2:0] == 3'h0)));
        // full master is the ungapped case of the same clock path
        next_clk_out = (mode == MODE_MASTER) && src_level && !gap_now;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            los_cnt <= '0;
            los_clk <= 1'b0;
            src_prev <= 1'b0;
            phase <= 1'b0;
            pos <= '0;
            start_pending <= 1'b0;
            locked <= 1'b0;
            rd_bank <= 1'b1;
            alt_tog <= 1'b0;
            rx_bp_clock_out <= 1'b0;
            rx_bp_clock_oe <= 1'b0;
            rx_bp_frame_pulse_out <= 1'b0;
            rx_bp_frame_pulse_oe <= 1'b0;
            rx_bp_data_out <= 1'b0;
            rx_bp_signaling_out <= 1'b0;
            mux_bp_data_out <= 1'b0;
            mux_bp_signaling_out <= 1'b0;
            mux_bp_data_oe <= 1'b0;
        end else begin
            los_cnt <= next_los_cnt;
            los_clk <= next_los_clk;
            src_prev <= src_level;
            phase <= next_phase;
            pos <= next_pos;
            start_pending <= next_start_pending;
            locked <= next_locked;
            rd_bank <= next_rd_bank;
            alt_tog <= next_alt_tog;
            rx_bp_clock_out <= next_clk_out;
            rx_bp_clock_oe <= (mode == MODE_MASTER);
            rx_bp_frame_pulse_out <= next_fp_out;
            rx_bp_frame_pulse_oe <= (mode == MODE_MASTER);
            rx_bp_data_out <= next_data;
            rx_bp_signaling_out <= next_sig;
            mux_bp_data_out <= next_data;
            mux_bp_signaling_out <= next_sig;
            mux_bp_data_oe <= next_mux_oe;
        end
    end
endmodule

// ==== pkg/rx_bp_pkg.sv ====
// constants for the receive backplane port: register map, control field layout,
// frame geometry and timing figures.
// assumes a 10 MHz system clock and 32-bit AHB-Lite register access.
package rx_bp_pkg;
    // register byte offsets
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] CH_GAP_ADDR = 8'h04;
    localparam logic [7:0] B8_GAP_ADDR = 8'h08;
    localparam logic [7:0] STATUS_ADDR = 8'h0C;

    // control register fields
    localparam int MUX_SEL_BIT = 0;
    localparam int SLAVE_SEL_BIT = 1;
    localparam int FRAME_EDGE_BIT = 2;
    localparam int DATA_EDGE_BIT = 3;
    localparam int MF_PULSE_BIT = 4;
    localparam int ALT_PULSE_BIT = 5;
    localparam int FP_INVERT_BIT = 6;
    localparam int FBIT_GAP_BIT = 7;
    localparam int PAYLOAD_EN_BIT = 8;
    localparam int CLK_DOUBLE_BIT = 9;
    localparam int DOUBLE_EDGE_BIT = 10;
    localparam int MAP_LSB = 12;
    localparam int MUX_SLOT_LSB = 14;
    localparam int OFFSET_IRQ_EN_BIT = 16;
    localparam int CTRL_WIDTH = 17;
    localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 17'h00000;

    // status register fields
    localparam int OFFSET_FLAG_BIT = 0;
    localparam int LOCKED_BIT = 1;

    // rate-mapping scheme codes
    localparam logic [1:0] MAP_T1_RATE = 2'h0;
    localparam logic [1:0] MAP_STANDARD = 2'h1;
    localparam logic [1:0] MAP_FILLER = 2'h2;
    localparam logic [1:0] MAP_CONTINUOUS = 2'h3;

    // frame geometry
    localparam int T1_CHANNELS = 24;
    localparam int T1_FRAME_BITS = 193;
    localparam logic [9:0] T1_LAST_BIT = 10'h0C0;
    localparam logic [9:0] E1_LAST_BIT = 10'h0FF;
    localparam logic [9:0] MUX_LAST_BIT = 10'h3FF;
    localparam logic [4:0] TS_STD_LOW_END = 5'h0F;
    localparam logic [4:0] TS_STD_HIGH_START = 5'h11;
    localparam logic [4:0] TS_STD_HIGH_END = 5'h19;
    localparam logic [4:0] TS_STD_FBIT = 5'h1A;
    localparam logic [4:0] TS_CONT_END = 5'h18;
    localparam logic [2:0] BIT8_POS = 3'h7;
    localparam logic [2:0] STD_FBIT_POS = 3'h0;

    // timing: recovered clock replacement while the line is lost
    localparam int MCLK_HZ = 10000000;
    localparam int T1_RATE_HZ = 1544000;
    localparam int LOS_HALF_CYCLES = MCLK_HZ / (2 * T1_RATE_HZ);

    // where a backplane bit is taken from
    typedef enum logic [1:0] {SRC_ZERO, SRC_CUR, SRC_NEXT_FBIT} src_e;
    typedef enum logic [1:0] {MODE_MASTER, MODE_SLAVE, MODE_MUX} mode_e;
endpackage

// ==== verification/rx_bp_port_assertions.sv ====
// checker for the receive backplane port: bus answers, pin drive per mode, interrupt gating
// assumes it is bound to rx_bp_port and sees only its ports
`timescale 1ns/1ps
module rx_bp_port_checker import rx_bp_pkg::*; (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic rx_bp_clock_oe,
    input wire logic rx_bp_frame_pulse_oe,
    input wire logic mux_bp_data_oe,
    input wire logic frame_pulse_irq
);
    logic [CTRL_WIDTH-1:0] ctrl;
    logic wr_ph;
    logic [7:0] wa;
    // shadow of the control word, so mode checks need no peek inside
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ctrl <= CTRL_RESET;
            wr_ph <= 1'b0;
            wa <= 8'h00;
        end else if (hready) begin
            wr_ph <= hsel && htrans[1] && hwrite && haddr[31:8] == 24'h000000;
            wa <= haddr[7:0];
            if (wr_ph && wa == CTRL_ADDR) ctrl <= hwdata[CTRL_WIDTH-1:0];
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence s_rd(logic [7:0] a);
        hsel && hready && htrans[1] && !hwrite && haddr == {24'h000000, a};
    endsequence
    a_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer not ready or not okay");
    a_oe_pair: assert property (rx_bp_clock_oe == rx_bp_frame_pulse_oe) else $error("clock and pulse drive differ");
    a_master_drive: assert property ((ctrl[1:0] == 2'h0) [*4] |-> rx_bp_clock_oe) else $error("master not driving");
    a_slave_release: assert property ((ctrl[1:0] == 2'h2) [*4] |-> !rx_bp_clock_oe && !rx_bp_frame_pulse_oe)
        else $error("slave still driving");
    a_mux_slot: assert property ((!ctrl[MUX_SEL_BIT]) [*3] |-> !mux_bp_data_oe) else $error("mux bus driven");
    a_irq_gate: assert property ((!ctrl[OFFSET_IRQ_EN_BIT]) [*3] |-> !frame_pulse_irq) else $error("irq not enabled");
    a_ctrl_read: assert property (s_rd(CTRL_ADDR) |=> hrdata == 32'($past(ctrl))) else $error("control readback wrong");
    a_unmapped_read: assert property (s_rd(8'h10) |=> hrdata == 32'h0) else $error("unmapped read not zero");
endmodule
bind rx_bp_port rx_bp_port_checker u_rx_bp_port_checker (.*);

// ==== verification/rx_bp_far_end.sv ====
// far-end backplane model: supplies slave clock and frame pulse, samples the data line
// assumes data is launched on the rising edge and settles well inside one bit
`timescale 1ns/1ps
module rx_bp_far_end (
    input wire logic run,
    input wire logic e1,
    input wire logic skew,
    input wire logic data_in,
    output logic clk = 1'b0,
    output logic fp = 1'b0,
    output logic smp = 1'b0,
    output int idx = 0
);
    int cnt = 0;
    // clock stands still while run is low; rate keeps one frame per line frame
    always begin
        #(e1 ? 301.5625 : 400.0);
        clk = run ? ~clk : clk;
    end
    // one pulse per whole frame, skew jumps the count to misplace one
    always @(posedge clk) begin
        cnt = skew ? 50 : (cnt + 1) % (e1 ? 256 : 193);
        idx = (cnt + (e1 ? 253 : 190)) % (e1 ? 256 : 193);
        smp = data_in;
    end
    always @(negedge clk) fp <= (cnt == 0);
endmodule

// ==== verification/testbench.sv ====
// bench for the receive backplane port: master clock spans, slave mapping, offset flag, registers
// assumes the far-end model keeps the slave clock in step with the line frame rate
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; $display("Error %s expected %h seen %h", n, e, g); end end
module testbench import rx_bp_pkg::*;;
    logic mclk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, line_clk = 1'b0, line_los = 1'b0;
    logic line_data = 1'b0, line_sig = 1'b0, line_frame_start = 1'b0, line_mf_start = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rs = 32'h3;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hready, hreadyout, hresp, rx_bp_clock_out, rx_bp_clock_oe, rx_bp_frame_pulse_out, rx_bp_frame_pulse_oe;
    logic rx_bp_data_out, rx_bp_signaling_out, mux_bp_data_out, mux_bp_signaling_out, mux_bp_data_oe, frame_pulse_irq;
    logic fclk, ffp, smp, run = 1'b0, e1 = 1'b0, skew = 1'b0, chk_en = 1'b0, inv = 1'b0, pc = 1'b0, pp = 1'b0;
    logic rd_ph = 1'b0;
    logic [1:0] cur_map = 2'h0;
    logic [63:0] ev;
    logic [63:0] exp_q[$];
    logic pat[193];
    int fails = 0, comparisons = 0, idx, lb = 0, fr = 0, ncl = 0, span = 0;
    logic [31:0] mc[8] = '{32'h0, 32'h40, 32'h180, 32'h100, 32'h10, 32'h20, 32'h30, 32'h0};
    logic [31:0] mg[8] = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0};
    int me[8] = '{193, 193, 192, 185, 386, 386, 772, 193};
    assign hready = hreadyout;
    rx_bp_port u_rx_bp_port (.mclk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
        .hreadyout, .hresp, .line_clk, .line_data, .line_sig, .line_frame_start, .line_mf_start, .line_los,
        .rx_bp_clock_in(fclk), .rx_bp_clock_out, .rx_bp_clock_oe, .rx_bp_frame_pulse_in(ffp), .rx_bp_frame_pulse_out,
        .rx_bp_frame_pulse_oe, .rx_bp_data_out, .rx_bp_signaling_out, .mux_bp_clock(fclk), .mux_bp_frame_pulse(ffp),
        .mux_bp_data_out, .mux_bp_signaling_out, .mux_bp_data_oe, .frame_pulse_irq);
    rx_bp_far_end u_rx_bp_far_end (.run, .e1, .skew, .data_in(rx_bp_data_out), .clk(fclk), .fp(ffp), .smp, .idx);
    always #50 mclk = ~mclk;
    always #400 line_clk = line_los ? line_clk : ~line_clk;
    function automatic void xs();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
    endfunction
    // the same random frame repeats, so any completed frame in the buffer is predictable
    always @(negedge line_clk) begin
        lb = (lb == 192) ? 0 : lb + 1;
        fr = (lb == 0) ? fr + 1 : fr;
        line_data <= pat[lb];
        line_sig <= ~pat[lb];
        line_frame_start <= (lb == 0);
        line_mf_start <= (lb == 0) && fr[0];
    end
    function automatic logic exp_bit(input logic [1:0] m, input int i);
        int ts, b, c;
        ts = i / 8;
        b = i % 8;
        c = 0;
        case (m)
            2'h0: return pat[i];
            2'h1: begin
                if (i == 208) return pat[0];
                c = (ts >= 1 && ts <= 15) ? ts : (ts >= 17 && ts <= 25) ? ts - 1 : 0;
            end
            2'h2: c = (ts % 4 == 0) ? 0 : ts - ts / 4;
            2'h3: c = (ts >= 1 && ts <= 24) ? ts : 0;
        endcase
        if (m != 2'h1 && i == 7) return pat[0];
        return (c != 0) ? pat[(c - 1) * 8 + b + 1] : 1'b0;
    endfunction
    always @(negedge fclk) if (chk_en) `CHK("rx data", exp_bit(cur_map, idx), smp)
    always @(posedge mclk) begin
        pc <= rx_bp_clock_out;
        pp <= rx_bp_frame_pulse_out ^ inv;
        ncl = (rx_bp_clock_out && !pc) ? ncl + 1 : ncl;
        if ((rx_bp_frame_pulse_out ^ inv) && !pp) begin
            span = ncl;
            ncl = 0;
        end
        if (rd_ph && hreadyout === 1'b1) begin
            ev = exp_q.pop_front();
            `CHK("hrdata", ev[31:0], hrdata & ev[63:32])
        end
        if (hreadyout) rd_ph <= hsel & htrans[1] & ~hwrite;
    end
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h000000, a};
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] mk);
        exp_q.push_back({mk, e});
        ahb(1'b0, a, 32'h0);
    endtask
    task automatic end_sim();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge mclk);
        fails++;
        end_sim();
    end
    initial begin
        for (int i = 0; i < 193; i++) begin
            xs();
            pat[i] = rs[0];
        end
        repeat (4) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        for (int i = 0; i < 8; i++) begin
            ahb(1'b1, CH_GAP_ADDR, mg[i]);
            ahb(1'b1, CTRL_ADDR, mc[i]);
            inv = mc[i][FP_INVERT_BIT];
            line_los <= (i == 7);
            repeat (16 * me[i] + 160) @(posedge mclk);
            `CHK("clock span", me[i], span)
        end
        $display("master spans done");
        inv = 1'b0;
        line_los <= 1'b0;
        run = 1'b1;
        for (int m = 0; m < 4; m++) begin
            cur_map = m[1:0];
            e1 = (m != 0);
            ahb(1'b1, CTRL_ADDR, 32'h0000000E | (32'(m) << 12) | ((m == 3) ? 32'h00010000 : 32'h0));
            repeat (4700) @(posedge mclk);
            chk_en = 1'b1;
            repeat (1800) @(posedge mclk);
            chk_en = 1'b0;
            $display("slave map %0d done", m);
        end
        ahb(1'b1, STATUS_ADDR, 32'h1);
        ahb(1'b1, 8'h10, 32'hFFFFFFFF);
        rd(STATUS_ADDR, 32'h0, 32'h1);
        rd(CTRL_ADDR, 32'h0001300E, 32'h0001FFFF);
        rd(8'h10, 32'h0, 32'hFFFFFFFF);
        @(negedge fclk);
        skew = 1'b1;
        @(negedge fclk);
        skew = 1'b0;
        repeat (3200) @(posedge mclk);
        rd(STATUS_ADDR, 32'h1, 32'h1);
        #1 `CHK("irq", 1'b1, frame_pulse_irq)
        $display("offset and registers done");
        end_sim();
    end
endmodule
